// ---- src/iot_pkg.sv ----
// package for the io timer channel block: offsets, fields, modes, carriers
// assumes a 32-bit axi4-lite master and synchronous pin inputs
package iot_pkg;

  // ****************************************************
  // sizes
  // ****************************************************
  localparam int          NCH      = 10;
  localparam int          CNT_W    = 16;
  localparam int          ADDR_W   = 12;
  localparam logic [15:0] CNT_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // ****************************************************
  // register map, byte addresses
  // ****************************************************
  localparam logic [3:0]  OFS_CNT  = 4'h0;
  localparam logic [3:0]  OFS_RL0  = 4'h4;
  localparam logic [3:0]  OFS_RL1  = 4'h8;
  localparam logic [3:0]  OFS_CTL  = 4'hC;
  localparam logic [11:0] ADR_PRO  = 12'h100;
  localparam logic [11:0] ADR_CEN  = 12'h104;
  localparam int          CH_LSB   = 4;
  localparam int          CH_MSB   = 7;
  localparam int          GLB_LSB  = 8;
  localparam int          MODE_LSB = 16;
  localparam int          MODE_MSB = 18;
  localparam int          LVL_BIT  = 19;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  localparam logic [1:0]  STRB_FULL = 2'h3;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [2:0] {
    MODE_MEAS_FREE,
    MODE_MEAS_CLR,
    MODE_NOISE,
    MODE_PWM,
    MODE_SSHOT,
    MODE_DSSHOT
  } iot_mode_e;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rl0w;
    logic [CNT_W-1:0] rl1w;
    logic [CNT_W-1:0] act1;
    logic [CNT_W-1:0] meas;
    logic [CNT_W-1:0] shadow;
    logic             hold;
    iot_mode_e        mode;
    logic             lvl;
    logic             cen;
    logic             pro;
    logic             phase;
    logic             parity;
    logic             pend;
    logic             need;
    logic             ext_prev;
    logic             tout;
    logic             irq;
  } iot_ch_s;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } iot_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } iot_axi_rsp_s;

endpackage

// ---- src/iot_timer.sv ----
// ten down-counting io timer channels behind an axi4-lite slave
// assumes count_tick and ext_in are synchronous to clk, ticks one cycle wide
// and never in two consecutive cycles
//
// Implementation choices: register access over AXI4-Lite and the register offsets.

// Operation
// - capture after counter write stores pre-write value
// - capture after measure clear stores pre-clear value
// - counter read returns live contents at once
// - noise: count at valid level, underflow interrupts, stops
// - noise: invalid level halts, return reloads and counts
// - noise: valid width is reload 0 plus 1
// - noise: underflow or enable write 0 stops
// - pwm: enable loads reload 0, then counts down
// - pwm: reload 0 first, then alternate per underflow
// - pwm: phases are reload 0+1, reload 1+1
// - pwm: enable write 0 stops immediately
// - pwm: output toggles at start and each underflow
// - pwm: interrupt only on even underflows
// - reload reads return written, not active, value
// - word write at reload 1 updates both
// - reload writes before reload-0 event apply now
// - single shot: load reload 0, stop at underflow
// - single shot: toggles at start and underflow
// - delayed shot: reload at first, stop second underflow
// - delayed shot: toggle and interrupt both underflows
// - collision priorities between enable, stop, writes
// - all ones readable one cycle after underflow
// - enable bit clears itself on underflow stop
// - enable writes ignored while protect bit set
module iot_timer
  import iot_pkg::*;
#(
  parameter int N = NCH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire iot_axi_req_s axi_req,
  output iot_axi_rsp_s      axi_rsp,
  input  wire logic [N-1:0] count_tick,
  input  wire logic [N-1:0] ext_in,
  output logic      [N-1:0] tout,
  output logic      [N-1:0] irq
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic              awrdy;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              wrdy;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    iot_ch_s [N-1:0]   ch;
  } iot_state_s;

  iot_state_s  state_reg;
  iot_state_s  state_next;
  iot_ch_s     o;
  iot_ch_s     c;
  logic        do_wr;
  logic        wr_ch_ok;
  logic        wr_lo;
  logic        wr_hi;
  logic [3:0]  wsel;
  logic [3:0]  wch;
  logic [3:0]  rch;
  logic [3:0]  rsel;
  logic        rd_ch_ok;
  logic [31:0] rdv;
  logic        rok;
  logic        sw1;
  logic        sw0;
  logic        edge_in;
  logic        lvl_ok;
  logic        cnt_go;
  logic        uf;
  logic        stop;
  logic        start;
  logic        ext_en;
  logic [CNT_W-1:0] cap;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    o          = '0;
    c          = '0;
    sw1        = 1'b0;
    sw0        = 1'b0;
    edge_in    = 1'b0;
    lvl_ok     = 1'b0;
    cnt_go     = 1'b0;
    uf         = 1'b0;
    stop       = 1'b0;
    start      = 1'b0;
    ext_en     = 1'b0;
    cap        = '0;
    rdv        = '0;
    rok        = 1'b0;

    // write address and data are taken independently, in either order
    if (state_reg.awrdy && axi_req.awvalid) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = axi_req.awaddr;
    end
    if (state_reg.wrdy && axi_req.wvalid) begin
      state_next.w_full = 1'b1;
      state_next.w_data = axi_req.wdata;
      state_next.w_strb = axi_req.wstrb;
    end
    do_wr    = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
    wch      = state_reg.aw_addr[CH_MSB:CH_LSB];
    wsel     = state_reg.aw_addr[CH_LSB-1:0];
    wr_ch_ok = (state_reg.aw_addr[ADDR_W-1:GLB_LSB] == '0)
               && (32'(wch) < 32'(N));
    // registers are halfword wide; byte writes to a half are dropped
    wr_lo    = (state_reg.w_strb[1:0] == STRB_FULL);
    wr_hi    = (state_reg.w_strb[3:2] == STRB_FULL);
    if (do_wr) begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = (wr_ch_ok || state_reg.aw_addr == ADR_PRO
                            || state_reg.aw_addr == ADR_CEN)
                           ? RESP_OK : RESP_ERR;
    end
    if (state_reg.bvalid && axi_req.bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awrdy = !state_next.aw_full;
    state_next.wrdy  = !state_next.w_full;

    // read decode
    rch      = axi_req.araddr[CH_MSB:CH_LSB];
    rsel     = axi_req.araddr[CH_LSB-1:0];
    rd_ch_ok = (axi_req.araddr[ADDR_W-1:GLB_LSB] == '0)
               && (32'(rch) < 32'(N));
    if (axi_req.araddr == ADR_PRO) begin
      rok = 1'b1;
      for (int i = 0; i < N; i++) begin
        rdv[i] = state_reg.ch[i].pro;
      end
    end else if (axi_req.araddr == ADR_CEN) begin
      rok = 1'b1;
      for (int i = 0; i < N; i++) begin
        rdv[i] = state_reg.ch[i].cen;
      end
    end else if (rd_ch_ok) begin
      rok = 1'b1;
      case (rsel)
        OFS_CNT: rdv[CNT_W-1:0] = state_reg.ch[rch].cnt;
        OFS_RL0: rdv[CNT_W-1:0] = state_reg.ch[rch].rl0w;
        OFS_RL1: rdv[CNT_W-1:0] = state_reg.ch[rch].rl1w;
        OFS_CTL: begin
          rdv[CNT_W-1:0]         = state_reg.ch[rch].meas;
          rdv[MODE_MSB:MODE_LSB] = state_reg.ch[rch].mode;
          rdv[LVL_BIT]           = state_reg.ch[rch].lvl;
        end
        default: rok = 1'b0;
      endcase
    end
    if (state_reg.arrdy && axi_req.arvalid) begin
      state_next.arrdy  = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rdata  = rdv;
      state_next.rresp  = rok ? RESP_OK : RESP_ERR;
    end
    if (state_reg.rvalid && axi_req.rready) begin
      state_next.rvalid = 1'b0;
      state_next.arrdy  = 1'b1;
    end

    // ****************************************************
    // channels
    // ****************************************************
    for (int i = 0; i < N; i++) begin
      o = state_reg.ch[i];
      c = o;
      c.irq      = 1'b0;
      c.ext_prev = ext_in[i];
      edge_in    = ext_in[i] && !o.ext_prev;
      lvl_ok     = (ext_in[i] == o.lvl);
      // protect bit gates enable writes
      sw1 = do_wr && wr_lo && state_reg.aw_addr == ADR_CEN && !o.pro
            && state_reg.w_data[i];
      sw0 = do_wr && wr_lo && state_reg.aw_addr == ADR_CEN && !o.pro
            && !state_reg.w_data[i];
      // pre-write value survives until the next tick
      cap = o.hold ? o.shadow : o.cnt;
      if (!o.hold) begin
        c.shadow = o.cnt;
      end
      if (count_tick[i]) begin
        c.hold = 1'b0;
      end

      // pending reload: the cycle after underflow shows all ones
      if (o.pend) begin
        c.pend = 1'b0;
        if (o.mode == MODE_PWM && o.phase) begin
          c.cnt = o.act1;
        end else begin
          c.cnt = o.rl0w;
          // reload 1 for this period is fixed at the reload-0 event
          c.act1 = o.rl1w;
        end
      end

      cnt_go = o.cen && count_tick[i] && !o.pend
               && (o.mode != MODE_NOISE || (lvl_ok && !o.need));
      uf     = cnt_go && (o.cnt == CNT_ZERO);
      if (cnt_go) begin
        c.cnt = o.cnt - 1'b1;
      end

      case (o.mode)
        MODE_MEAS_FREE, MODE_MEAS_CLR: begin
          if (uf) begin
            c.irq = 1'b1;
          end
          if (o.cen && edge_in) begin
            c.meas = cap;
            c.irq  = 1'b1;
            if (o.mode == MODE_MEAS_CLR) begin
              c.cnt  = CNT_ONES;
              c.hold = 1'b1;
            end
          end
        end
        MODE_NOISE: begin
          if (o.cen && !lvl_ok) begin
            c.need = 1'b1;
          end else if (o.cen && o.need) begin
            c.cnt  = o.rl0w;
            c.need = 1'b0;
          end
          if (uf) begin
            stop  = 1'b1;
            c.irq = 1'b1;
          end
        end
        MODE_PWM: begin
          if (uf) begin
            c.pend   = 1'b1;
            c.phase  = !o.phase;
            c.tout   = !o.tout;
            c.parity = !o.parity;
            c.irq    = o.parity;
          end
        end
        MODE_SSHOT: begin
          if (uf) begin
            stop   = 1'b1;
            c.tout = !o.tout;
            c.irq  = 1'b1;
          end
        end
        MODE_DSSHOT: begin
          if (uf) begin
            c.tout  = !o.tout;
            c.irq   = 1'b1;
            c.phase = 1'b1;
            if (o.phase) begin
              stop = 1'b1;
            end else begin
              c.pend = 1'b1;
            end
          end
        end
        default: begin
          c.cen = 1'b0;
        end
      endcase

      // enable arbitration in one cycle
      ext_en = edge_in && (o.mode == MODE_PWM || o.mode == MODE_SSHOT
                           || o.mode == MODE_DSSHOT);
      start  = (sw1 && (!o.cen || stop))
               || (ext_en && !o.cen && !sw0);
      if (sw1) begin
        c.cen = 1'b1;
      end else if (sw0) begin
        c.cen  = 1'b0;
        c.pend = 1'b0;
      end else if (stop) begin
        c.cen = 1'b0;
      end else if (start) begin
        c.cen = 1'b1;
      end
      if (start) begin
        c.pend   = 1'b0;
        c.need   = 1'b1;
        c.phase  = 1'b0;
        c.parity = 1'b0;
        if (o.mode == MODE_PWM || o.mode == MODE_SSHOT) begin
          c.cnt  = o.rl0w;
          c.act1 = o.rl1w;
          c.tout = !c.tout;
        end
      end

      // software writes to the channel's own registers
      if (do_wr && wr_ch_ok && 32'(wch) == i) begin
        case (wsel)
          OFS_CNT: begin
            if (wr_lo) begin
              c.cnt  = state_reg.w_data[CNT_W-1:0];
              c.hold = 1'b1;
            end
          end
          OFS_RL0: begin
            if (wr_lo) begin
              c.rl0w = state_reg.w_data[CNT_W-1:0];
            end
          end
          OFS_RL1: begin
            // a word write lands reload 1 and reload 0 together, so
            // no reload event can see only one of them
            if (wr_lo) begin
              c.rl1w = state_reg.w_data[CNT_W-1:0];
            end
            if (wr_hi) begin
              c.rl0w = state_reg.w_data[31:CNT_W];
            end
          end
          OFS_CTL: begin
            if (wr_hi) begin
              c.mode = iot_mode_e'(state_reg.w_data[MODE_MSB:MODE_LSB]);
              c.lvl  = state_reg.w_data[LVL_BIT];
            end
          end
          default: begin
            c.rl0w = o.rl0w;
          end
        endcase
      end
      if (do_wr && wr_lo && state_reg.aw_addr == ADR_PRO) begin
        c.pro = state_reg.w_data[i];
      end
      state_next.ch[i] = c;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= '0;
      state_reg.awrdy <= 1'b1;
      state_reg.wrdy  <= 1'b1;
      state_reg.arrdy <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign axi_rsp.awready = state_reg.awrdy;
  assign axi_rsp.wready  = state_reg.wrdy;
  assign axi_rsp.bvalid  = state_reg.bvalid;
  assign axi_rsp.bresp   = state_reg.bresp;
  assign axi_rsp.arready = state_reg.arrdy;
  assign axi_rsp.rvalid  = state_reg.rvalid;
  assign axi_rsp.rdata   = state_reg.rdata;
  assign axi_rsp.rresp   = state_reg.rresp;

  for (genvar g = 0; g < N; g++) begin : g_out
    assign tout[g] = state_reg.ch[g].tout;
    assign irq[g]  = state_reg.ch[g].irq;
  end

endmodule

// ---- verification/iot_timer_checker.sv ----
// port checker for the io timer block
// assumes a bind from the bench, one clock domain
module iot_timer_checker
  import iot_pkg::*;
#(
  parameter int N = NCH
) (
  input wire logic         clk,
  input wire logic         rst,
  input wire iot_axi_req_s axi_req,
  input wire iot_axi_rsp_s axi_rsp,
  input wire logic [N-1:0] count_tick,
  input wire logic [N-1:0] ext_in,
  input wire logic [N-1:0] tout,
  input wire logic [N-1:0] irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // relations
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  rd_answer_a: assert property (
    axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer not one cycle after take");
  rd_hold_a: assert property (
    axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  rd_err_a: assert property (
    axi_rsp.rvalid && axi_rsp.rresp == RESP_ERR
      |-> axi_rsp.rdata == 32'h0000_0000)
    else $error("error read with data");
  wr_hold_a: assert property (
    axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  wr_drain_a: assert property (
    axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid && axi_rsp.awready)
    else $error("write channel not freed");
  aw_busy_a: assert property (
    axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("second write taken while busy");
  // output only moves on a tick, a write or a pin edge
  tout_cause_a: assert property (
    $changed(tout) |-> $rose(axi_rsp.bvalid) || $past(count_tick) != '0
      || $past(ext_in) != $past(ext_in, 2)
      || $past(ext_in, 2) != $past(ext_in, 3))
    else $error("output toggled without cause");
  irq_cause_a: assert property (
    irq != '0 |-> $past(count_tick) != '0 || $past(count_tick, 2) != '0
      || $past(ext_in) != $past(ext_in, 2)
      || $past(ext_in, 2) != $past(ext_in, 3))
    else $error("interrupt without cause");
endmodule

// ---- verification/iot_pin_model.sv ----
// pin-side model: count clock enables and the external pin
// assumes the bench sets period (2 or more) and the wanted pin level
module iot_pin_model
  import iot_pkg::*;
#(
  parameter int N = NCH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   period,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] count_tick,
  output logic      [N-1:0] ext_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] div_reg;

  // ticks never back to back, so none lands in a reload cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg    <= 8'h00;
      count_tick <= '0;
      ext_in     <= '0;
    end else begin
      ext_in <= level;
      if (div_reg + 8'h01 >= period) begin
        div_reg    <= 8'h00;
        count_tick <= '1;
      end else begin
        div_reg    <= div_reg + 8'h01;
        count_tick <= '0;
      end
    end
  end
endmodule

// ---- verification/iot_timer_test.sv ----
// bench for the io timer block: axi4-lite tasks, channel 0 scenarios
// assumes the pin model for ticks and the external pin
module iot_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import iot_pkg::*;
  iot_axi_req_s   req;
  iot_axi_rsp_s   rsp;
  logic           clk, rst, tprev;
  logic [7:0]     period;
  logic [NCH-1:0] level, count_tick, ext_in, tout, irq;
  logic [31:0]    rd_v, v;
  logic [1:0]     resp;
  int             fail_count, samples_checked, tk, nirq, w0, n0;
  int             widths[$];

  iot_timer iot_timer_inst (.clk(clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .count_tick(count_tick), .ext_in(ext_in),
    .tout(tout), .irq(irq));
  iot_pin_model iot_pin_model_inst (.clk(clk), .rst(rst), .period(period),
    .level(level), .count_tick(count_tick), .ext_in(ext_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****
  // monitor, tasks
  // ****
  // ticks per output phase, pushed one cycle after each toggle
  always @(posedge clk) begin
    if (tout[0] !== tprev) begin
      widths.push_back(tk);
      tk = int'(count_tick[0]);
    end else tk = tk + int'(count_tick[0]);
    tprev = tout[0];
    if (irq[0] === 1'b1) nirq = nirq + 1;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tmo(input bit hit);
    if (hit) begin
      fail_count++;
      stop_test();
    end
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    bit aw, w;
    @(posedge clk);
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (rsp.bvalid !== 1'b1 && n < 40);
    req.bready <= 1'b0;
    resp = rsp.bresp;
    tmo(n >= 40);
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 40);
    req.rready <= 1'b0;
    rd_v = rsp.rdata;
    resp = rsp.rresp;
    tmo(n >= 40);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_v, exp);
  endtask

  task automatic ticks(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 2000) begin
      @(posedge clk);
      n++;
      if (count_tick[0] === 1'b1) k--;
    end
    tmo(n >= 2000);
  endtask

  task automatic setup(input logic [2:0] m, input logic l,
                       input logic [31:0] r);
    wr(12'h008, r);
    wr(12'h00C, {12'h000, l, m, 16'h0000});
    w0 = widths.size();
    n0 = nirq;
  endtask

  // ****
  // scenarios
  // ****
  initial begin
    rst = 1'b1;
    req = '0;
    level = '0;
    period = 8'h03;
    tprev = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(ADR_CEN, 32'h0000_0000);
    rdc(12'h200, 32'h0000_0000);
    check(32'(resp), 32'(RESP_ERR));
    wr(ADR_PRO, 32'h0000_0004);
    wr(ADR_CEN, 32'h0000_0004);
    rdc(ADR_CEN, 32'h0000_0000);
    wr(ADR_PRO, 32'h0000_0000);
    $display("reset, map and protect done");
    setup(3'h3, 1'b0, 32'h0002_0004);
    rdc(12'h004, 32'h0000_0002);
    rdc(12'h008, 32'h0000_0004);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(17);
    check(widths.size() - w0, 5);
    for (int i = 1; i < 5; i++) begin
      check(widths[w0+i], i[0] ? 3 : 5);
    end
    check(nirq - n0, 2);
    wr(ADR_CEN, 32'h0000_0000);
    rd(12'h000);
    v = rd_v;
    ticks(3);
    rdc(12'h000, v);
    $display("pwm done");
    setup(3'h4, 1'b0, 32'h0003_0000);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(8);
    check(widths.size() - w0, 2);
    check(widths[w0+1], 4);
    check(nirq - n0, 1);
    rdc(ADR_CEN, 32'h0000_0000);
    $display("single shot done");
    setup(3'h5, 1'b0, 32'h0002_0000);
    wr(12'h000, 32'h0000_0001);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(8);
    check(widths.size() - w0, 2);
    check(widths[w0+1], 3);
    check(nirq - n0, 2);
    rdc(ADR_CEN, 32'h0000_0000);
    $display("delayed shot done");
    setup(3'h2, 1'b1, 32'h0004_0000);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(1);
    level[0] <= 1'b1;
    ticks(2);
    level[0] <= 1'b0;
    ticks(8);
    check(nirq - n0, 0);
    ticks(1);
    level[0] <= 1'b1;
    ticks(4);
    check(nirq - n0, 0);
    ticks(2);
    check(nirq - n0, 1);
    rdc(ADR_CEN, 32'h0000_0000);
    level[0] <= 1'b0;
    $display("noise done");
    period <= 8'h14;
    setup(3'h0, 1'b0, 32'h0000_0000);
    wr(12'h000, 32'h0000_0100);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(2);
    rd(12'h000);
    v = rd_v;
    wr(12'h000, 32'h0000_0050);
    rdc(12'h000, 32'h0000_0050);
    level[0] <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(12'h00C, {16'h0000, v[15:0]});
    wr(ADR_CEN, 32'h0000_0000);
    $display("measure done");
    // two captures inside one slow tick period
    level[0] <= 1'b0;
    period <= 8'h20;
    setup(3'h1, 1'b0, 32'h0000_0000);
    wr(12'h000, 32'h0000_0200);
    wr(ADR_CEN, 32'h0000_0001);
    ticks(1);
    rd(12'h000);
    v = rd_v;
    level[0] <= 1'b1;
    repeat (3) @(posedge clk);
    level[0] <= 1'b0;
    repeat (2) @(posedge clk);
    level[0] <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(12'h00C, {12'h000, 1'b0, 3'h1, v[15:0]});
    rdc(12'h000, 32'h0000_FFFF);
    wr(ADR_CEN, 32'h0000_0000);
    $display("measure clear done");
    // pin enable landing with a stop write must lose
    level[0] <= 1'b0;
    period <= 8'h03;
    setup(3'h4, 1'b0, 32'h0001_0000);
    fork
      wr(ADR_CEN, 32'h0000_0000);
      begin
        @(posedge clk);
        level[0] <= 1'b1;
      end
    join
    rdc(ADR_CEN, 32'h0000_0000);
    check(widths.size() - w0, 0);
    level[0] <= 1'b0;
    repeat (2) @(posedge clk);
    level[0] <= 1'b1;
    ticks(6);
    check(widths.size() - w0, 2);
    check(widths[w0+1], 2);
    check(nirq - n0, 1);
    rdc(ADR_CEN, 32'h0000_0000);
    $display("external enable done");
    stop_test();
  end
endmodule

bind iot_timer iot_timer_checker #(.N(N)) iot_timer_checker_inst (
  .clk(clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .count_tick(count_tick), .ext_in(ext_in), .tout(tout), .irq(irq));
